// ==== hdl/ppm_top.sv ====
// Pulse parameter measurement engine with APB registers and panel keys
`timescale 1ns/10ps
`default_nettype none
`include "ppm_cfg.svh"
module ppm_top
  import ppm_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Record memory, one cycle read latency
  input wire logic rec_refresh,
  input wire logic [7:0] rec_data,
  output logic [12:0] rec_addr,
  output logic [1:0] rec_chan,
  // Front panel pins
  input wire logic key_measure,
  input wire logic key_select,
  input wire logic knob_up,
  input wire logic knob_down,
  // Readouts
  output var ppm_readout_t [3:0] readout,
  output var ppm_meas_t meas_mode,
  output logic [2:0] highlight,
  output logic busy
);
  // ------------------------------------------------------------
  // Panel keys
  // ------------------------------------------------------------
  logic [3:0] ks1;
  logic [3:0] ks2;
  logic [3:0] kprev;
  logic [3:0] kpress;
  // Pins are asynchronous; the third flop only serves the edge
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ks1 <= 4'h0;
      ks2 <= 4'h0;
      kprev <= 4'h0;
    end else begin
      ks1 <= {knob_down, knob_up, key_select, key_measure};
      ks2 <= ks1;
      kprev <= ks2;
    end
  end
  assign kpress = ks2 & ~kprev;

  // ------------------------------------------------------------
  // Registers and APB
  // ------------------------------------------------------------
  logic [3:0] ctrl, next_ctrl;
  ppm_par_t [3:0] slot, next_slot;
  ppm_meas_t next_mode;
  logic [2:0] next_hl;
  logic [31:0] next_prdata;
  logic [3:0] hit;
  logic [1:0] hsel;
  ppm_state_t st, next_st;
  logic [5:0] flags;

  // Returns {valid, index}; shared by read, write and error paths
  function automatic logic [3:0] reg_hit(input logic [11:0] a);
    logic [3:0] r;
    r = 4'h0;
    case (a)
      `PPM_A_CTRL: r = 4'h8;
      `PPM_A_SLOTS: r = 4'h9;
      `PPM_A_STAT: r = 4'hA;
      `PPM_A_RES0: r = 4'hC;
      `PPM_A_RES1: r = 4'hD;
      `PPM_A_RES2: r = 4'hE;
      `PPM_A_RES3: r = 4'hF;
      default: r = 4'h0;
    endcase
    return r;
  endfunction

  assign hit = reg_hit(paddr);
  assign hsel = 2'(highlight - 3'h1);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit[3];
  assign rec_chan = ctrl[1:0];

  // Next register values from bus and panel
  always_comb begin
    next_ctrl = ctrl;
    next_slot = slot;
    next_mode = meas_mode;
    next_hl = highlight;
    next_prdata = prdata;
    if (psel && penable && pwrite && hit == 4'h8) begin
      next_ctrl = pwdata[3:0];
    end
    if (psel && penable && pwrite && hit == 4'h9) begin
      for (int i = 0; i < 4; i++) begin
        next_slot[i] = ppm_par_t'(pwdata[5*i +: 5] > 5'(PAR_AVG) ? 5'h0 : pwdata[5*i +: 5]);
      end
    end
    // Setup phase loads read data so it comes from a flop
    if (psel && !penable) begin
      case (hit)
        4'h8: next_prdata = {28'h0, ctrl};
        4'h9: next_prdata = {12'h0, slot};
        4'hA: next_prdata = {19'h0, flags, highlight, meas_mode, busy};
        4'hC, 4'hD, 4'hE, 4'hF: next_prdata = readout[hit[1:0]].value;
        default: next_prdata = 32'h0;
      endcase
    end
    // Fixed order; parameters only reachable from cross cursors
    if (kpress[0]) begin
      case (meas_mode)
        M_OFF: next_mode = M_VCUR;
        M_VCUR: next_mode = M_TCUR;
        M_TCUR: next_mode = M_XCUR;
        M_XCUR: next_mode = M_PARAM;
        default: next_mode = M_OFF;
      endcase
    end
    if (kpress[1]) begin
      next_hl = (highlight == 3'h0 || highlight == 3'h4) ? 3'h1 : 3'(highlight + 3'h1);
    end
    // Knob wraps through the parameter set in the highlighted slot
    if (highlight != 3'h0 && kpress[2]) begin
      next_slot[hsel] = slot[hsel] == PAR_AVG ? PAR_REPETITION_RATE : ppm_par_t'(slot[hsel] + 5'h1);
    end else if (highlight != 3'h0 && kpress[3]) begin
      next_slot[hsel] = slot[hsel] == PAR_REPETITION_RATE ? PAR_AVG : ppm_par_t'(slot[hsel] - 5'h1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl <= `PPM_CTRL_RST;
      // Unpacked per slot so each code is cast to the enum on its own
      for (int i = 0; i < 4; i++) begin
        slot[i] <= ppm_par_t'(5'(`PPM_SLOTS_RST >> (5 * i)));
      end
      meas_mode <= M_OFF;
      highlight <= 3'h0;
      prdata <= 32'h0;
    end else begin
      ctrl <= next_ctrl;
      slot <= next_slot;
      meas_mode <= next_mode;
      highlight <= next_hl;
      prdata <= next_prdata;
    end
  end

  // ------------------------------------------------------------
  // Measurement engine
  // ------------------------------------------------------------
  logic [13:0] hist [256];
  logic [13:0] next_hist [256];
  logic [13:0] len, next_len, addr, next_addr, sidx, next_sidx;
  logic rd_v, next_rd_v, issue;
  logic [7:0] vmin, vmax, next_vmin, next_vmax, base, top, next_base, next_top;
  logic [7:0] lo_v, hi_v, next_lo_v, next_hi_v, th_lo, th_mid, th_hi;
  logic [7:0] next_th_lo, next_th_mid, next_th_hi, mid, swing;
  logic [13:0] pk_lo, pk_hi, next_pk_lo, next_pk_hi;
  logic [8:0] bin, next_bin;
  logic [1:0] ncr, next_ncr;
  logic above, next_above, fdir, next_fdir;
  logic [13:0] c0, c1, c2, next_c0, next_c1, next_c2;
  logic [13:0] t_lo, t_hi, next_t_lo, next_t_hi, rise_t, fall_t;
  logic [13:0] next_rise_t, next_fall_t;
  logic arm_r, arm_f, hv_r, hv_f, next_arm_r, next_arm_f, next_hv_r, next_hv_f;
  logic [20:0] acc_s, next_acc_s;
  logic [28:0] acc_q, next_acc_q;
  logic [31:0] mean, next_mean, repetition_rate, next_repetition_rate, duty, next_duty;
  logic [15:0] msq, next_msq;
  logic [7:0] root, next_root, trial;
  logic [2:0] kbit, next_kbit;
  logic [13:0] cycle_time, pw, nw;
  logic cyc_ok, edge_ok, hi_now, weak_lo, weak_hi, rise_seen, fall_seen;
  logic [23:0] amp24;

  assign busy = st != S_IDLE;
  assign rec_addr = addr[12:0];
  assign issue = addr < len;
  assign mid = 8'(({1'b0, vmin} + {1'b0, vmax}) >> 1);
  assign swing = 8'(top - base);
  assign amp24 = {16'h0, swing};
  assign hi_now = rec_data >= th_mid;
  assign trial = root | 8'(8'h1 << kbit);
  assign weak_lo = {10'h0, pk_lo} * `PPM_PCT_FULL < {10'h0, len} * `PPM_PEAK_PCT;
  assign weak_hi = {10'h0, pk_hi} * `PPM_PCT_FULL < {10'h0, len} * `PPM_PEAK_PCT;
  // First pulse and first period from the first three crossings
  assign cyc_ok = ncr == 2'h3;
  assign edge_ok = ncr != 2'h0;
  assign cycle_time = 14'(c2 - c0);
  assign pw = fdir ? 14'(c1 - c0) : 14'(c2 - c1);
  assign nw = fdir ? 14'(c2 - c1) : 14'(c1 - c0);
  assign flags = {cyc_ok, hv_f, hv_r, ncr >= 2'h2, edge_ok, fdir};
  // A flat record meets both bands at once, so a true mid crossing is also needed
  assign rise_seen = ncr >= 2'h2 || (edge_ok && fdir);
  assign fall_seen = ncr >= 2'h2 || (edge_ok && !fdir);

  // Next engine values; one record pass in S_HIST and one in S_EDGE
  always_comb begin
    next_st = st;
    next_hist = hist;
    next_len = len;
    next_addr = addr;
    next_sidx = addr;
    next_rd_v = 1'b0;
    next_vmin = vmin;
    next_vmax = vmax;
    next_base = base;
    next_top = top;
    next_lo_v = lo_v;
    next_hi_v = hi_v;
    next_pk_lo = pk_lo;
    next_pk_hi = pk_hi;
    next_bin = bin;
    next_th_lo = th_lo;
    next_th_mid = th_mid;
    next_th_hi = th_hi;
    next_ncr = ncr;
    next_above = above;
    next_fdir = fdir;
    next_c0 = c0;
    next_c1 = c1;
    next_c2 = c2;
    next_t_lo = t_lo;
    next_t_hi = t_hi;
    next_rise_t = rise_t;
    next_fall_t = fall_t;
    next_arm_r = arm_r;
    next_arm_f = arm_f;
    next_hv_r = hv_r;
    next_hv_f = hv_f;
    next_acc_s = acc_s;
    next_acc_q = acc_q;
    next_mean = mean;
    next_msq = msq;
    next_repetition_rate = repetition_rate;
    next_duty = duty;
    next_root = root;
    next_kbit = kbit;
    case (st)
      S_IDLE: begin
        // A refresh during a run is ignored; the next one is taken
        if (rec_refresh) begin
          next_st = S_HIST;
          next_len = (ctrl[`PPM_CTRL_DENSE] || ctrl[`PPM_CTRL_ACCUM]) ?
                     `PPM_LEN_LONG : `PPM_LEN_NORM;
          next_addr = 14'h0;
          next_vmin = 8'hFF;
          next_vmax = 8'h00;
          for (int i = 0; i < 256; i++) begin
            next_hist[i] = 14'h0;
          end
        end
      end
      S_HIST: begin
        next_rd_v = issue;
        if (issue) begin
          next_addr = 14'(addr + 14'h1);
        end
        if (rd_v) begin
          next_hist[rec_data] = 14'(hist[rec_data] + 14'h1);
          if (rec_data < vmin) next_vmin = rec_data;
          if (rec_data > vmax) next_vmax = rec_data;
        end
        if (!issue && !rd_v) begin
          next_st = S_LVL;
          next_bin = 9'h0;
          next_pk_lo = 14'h0;
          next_pk_hi = 14'h0;
          next_lo_v = vmin;
          next_hi_v = vmax;
        end
      end
      S_LVL: begin
        // Peak search on each side of the midpoint
        if (bin[7:0] < mid) begin
          if (hist[bin[7:0]] > pk_lo) begin
            next_pk_lo = hist[bin[7:0]];
            next_lo_v = bin[7:0];
          end
        end else if (hist[bin[7:0]] > pk_hi) begin
          next_pk_hi = hist[bin[7:0]];
          next_hi_v = bin[7:0];
        end
        next_bin = 9'(bin + 9'h1);
        // Threshold phase spends one cycle on levels and one on thresholds
        if (bin == 9'h0FF) begin
          next_st = S_THR;
          next_bin = 9'h0;
        end
      end
      S_THR: begin
        next_base = weak_lo ? vmin : lo_v;
        next_top = weak_hi ? vmax : hi_v;
        next_th_lo = 8'(base + 8'(amp24 * `PPM_LO_PCT / `PPM_PCT_FULL));
        next_th_mid = 8'(base + 8'(amp24 * `PPM_MID_PCT / `PPM_PCT_FULL));
        next_th_hi = 8'(base + 8'(amp24 * `PPM_HI_PCT / `PPM_PCT_FULL));
        // Levels settle first, thresholds follow one cycle later
        if (bin == 9'h100) begin
          next_st = S_EDGE;
          next_addr = 14'h0;
          next_ncr = 2'h0;
          {next_arm_r, next_arm_f, next_hv_r, next_hv_f} = 4'h0;
          next_acc_s = 21'h0;
          next_acc_q = 29'h0;
          next_rise_t = 14'h0;
          next_fall_t = 14'h0;
        end
        next_bin = 9'h100;
      end
      S_EDGE: begin
        next_rd_v = issue;
        if (issue) begin
          next_addr = 14'(addr + 14'h1);
        end
        if (rd_v) begin
          // Only the first three mid crossings are kept
          if (sidx == 14'h0) begin
            next_above = hi_now;
          end else if (hi_now != above && ncr != 2'h3) begin
            next_above = hi_now;
            next_ncr = 2'(ncr + 2'h1);
            if (ncr == 2'h0) begin
              next_c0 = sidx;
              next_fdir = hi_now;
            end
            if (ncr == 2'h1) next_c1 = sidx;
            if (ncr == 2'h2) next_c2 = sidx;
          end
          if (next_ncr == 2'h1 || next_ncr == 2'h2) begin
            next_acc_s = 21'(acc_s + {13'h0, rec_data});
            next_acc_q = 29'(acc_q + {21'h0, rec_data} * {21'h0, rec_data});
          end
          // Last low-band sample before the first high-band sample
          if (rec_data <= th_lo) begin
            next_t_lo = sidx;
            next_arm_r = 1'b1;
          end
          if (rec_data >= th_hi && arm_r && !hv_r) begin
            next_rise_t = 14'(sidx - t_lo);
            next_hv_r = 1'b1;
          end
          if (rec_data >= th_hi) begin
            next_t_hi = sidx;
            next_arm_f = 1'b1;
          end
          if (rec_data <= th_lo && arm_f && !hv_f) begin
            next_fall_t = 14'(sidx - t_hi);
            next_hv_f = 1'b1;
          end
        end
        if (!issue && !rd_v) begin
          next_st = S_MATH;
        end
      end
      S_MATH: begin
        if (cyc_ok && cycle_time != 14'h0) begin
          next_mean = 32'(acc_s / {7'h0, cycle_time});
          next_msq = 16'(acc_q / {15'h0, cycle_time});
          next_repetition_rate = `PPM_RATE_SCALE / {18'h0, cycle_time};
          next_duty = 32'({18'h0, pw} * `PPM_PCT_FULL / {10'h0, cycle_time});
        end else begin
          next_mean = 32'h0;
          next_msq = 16'h0;
          next_repetition_rate = 32'h0;
          next_duty = 32'h0;
        end
        next_root = 8'h0;
        next_kbit = 3'h7;
        next_st = S_ROOT;
      end
      S_ROOT: begin
        // Bit-serial square root, eight cycles
        if ({8'h0, trial} * {8'h0, trial} <= msq) begin
          next_root = trial;
        end
        next_kbit = 3'(kbit - 3'h1);
        if (kbit == 3'h0) next_st = S_DONE;
      end
      S_DONE: next_st = S_IDLE;
      default: next_st = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st <= S_IDLE;
      len <= `PPM_LEN_NORM;
      {addr, sidx, c0, c1, c2, t_lo, t_hi, rise_t, fall_t} <= 126'h0;
      rd_v <= 1'b0;
      {vmin, vmax, base, top, lo_v, hi_v, th_lo, th_mid, th_hi} <= 72'h0;
      {pk_lo, pk_hi} <= 28'h0;
      bin <= 9'h0;
      {ncr, above, fdir, arm_r, arm_f, hv_r, hv_f} <= 8'h0;
      {acc_s, acc_q} <= 50'h0;
      {mean, repetition_rate, duty} <= 96'h0;
      msq <= 16'h0;
      root <= 8'h0;
      kbit <= 3'h0;
      for (int i = 0; i < 256; i++) begin
        hist[i] <= 14'h0;
      end
    end else begin
      st <= next_st;
      len <= next_len;
      {addr, sidx, c0, c1, c2} <= {next_addr, next_sidx, next_c0, next_c1, next_c2};
      {t_lo, t_hi, rise_t, fall_t} <= {next_t_lo, next_t_hi, next_rise_t, next_fall_t};
      rd_v <= next_rd_v;
      {vmin, vmax, base, top} <= {next_vmin, next_vmax, next_base, next_top};
      {lo_v, hi_v, th_lo, th_mid, th_hi} <= {next_lo_v, next_hi_v, next_th_lo,
                                              next_th_mid, next_th_hi};
      {pk_lo, pk_hi} <= {next_pk_lo, next_pk_hi};
      bin <= next_bin;
      {ncr, above, fdir} <= {next_ncr, next_above, next_fdir};
      {arm_r, arm_f, hv_r, hv_f} <= {next_arm_r, next_arm_f, next_hv_r, next_hv_f};
      {acc_s, acc_q} <= {next_acc_s, next_acc_q};
      {mean, repetition_rate, duty} <= {next_mean, next_repetition_rate, next_duty};
      msq <= next_msq;
      root <= next_root;
      kbit <= next_kbit;
      hist <= next_hist;
    end
  end

  // ------------------------------------------------------------
  // Readout slots
  // ------------------------------------------------------------
  // Value of one parameter; zero where its prerequisite is absent
  function automatic logic [31:0] pval(input ppm_par_t p);
    logic [31:0] v;
    v = 32'h0;
    case (p)
      PAR_REPETITION_RATE: v = repetition_rate;
      PAR_PER: v = cyc_ok ? {18'h0, cycle_time} : 32'h0;
      PAR_RISE: v = hv_r && rise_seen ? {18'h0, rise_t} : 32'h0;
      PAR_FALL: v = hv_f && fall_seen ? {18'h0, fall_t} : 32'h0;
      PAR_PWID: v = (fdir ? ncr >= 2'h2 : cyc_ok) ? {18'h0, pw} : 32'h0;
      PAR_NWID: v = (fdir ? cyc_ok : ncr >= 2'h2) ? {18'h0, nw} : 32'h0;
      PAR_DUTY: v = duty;
      PAR_MIN: v = {24'h0, vmin};
      PAR_MAX: v = {24'h0, vmax};
      PAR_PP: v = {24'h0, 8'(vmax - vmin)};
      PAR_BASE: v = {24'h0, base};
      PAR_TOP: v = {24'h0, top};
      PAR_AMP: v = {24'h0, swing};
      PAR_PRE: v = !edge_ok ? 32'h0 : {24'h0, fdir ? 8'(base - vmin) : 8'(vmax - top)};
      PAR_OVER: v = !edge_ok ? 32'h0 : {24'h0, fdir ? 8'(vmax - top) : 8'(base - vmin)};
      PAR_RMS: v = {24'h0, root};
      PAR_AVG: v = mean;
      default: v = 32'h0;
    endcase
    return v;
  endfunction

  for (genvar g = 0; g < 4; g++) begin : g_slot
    ppm_readout_t next_ro;
    // Publish all four together when a run completes
    always_comb begin
      next_ro = readout[g];
      if (st == S_DONE) begin
        next_ro.par = slot[g];
        next_ro.chan = ctrl[1:0];
        next_ro.value = pval(slot[g]);
      end
    end
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        readout[g] <= '0;
      end else begin
        readout[g] <= next_ro;
      end
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence seq_pub;
    st == S_DONE;
  endsequence
  sequence seq_take;
    st == S_IDLE && rec_refresh;
  endsequence

  a_low_level_pick: assert property (st == S_THR && weak_lo |=> base == $past(vmin))
    else $error("low level not minimum");
  a_high_level_pick: assert property (st == S_THR && !weak_hi |=> top == $past(hi_v))
    else $error("high level not peak");
  a_swing_value: assert property (seq_pub ##0 slot[0] == PAR_AMP |=>
    readout[0].value == {24'h0, 8'(top - base)})
    else $error("swing wrong");
  a_cycle_zero: assert property (seq_pub ##0 !cyc_ok ##0 slot[0] == PAR_AVG |=>
    readout[0].value == 32'h0)
    else $error("mean without period");
  a_rise_zero: assert property (seq_pub ##0 !hv_r ##0 slot[1] == PAR_RISE |=>
    readout[1].value == 32'h0)
    else $error("rise without edge");
  a_chan_tag: assert property (seq_pub |=> readout[3].chan == $past(ctrl[1:0]))
    else $error("channel tag wrong");
  a_first_highlight: assert property (kpress[1] && highlight == 3'h0 |=>
    highlight == 3'h1)
    else $error("select did not go to slot one");
  a_mode_step: assert property (kpress[0] && meas_mode == M_XCUR |=>
    meas_mode == M_PARAM)
    else $error("parameter mode not after cross");
  a_refresh_run: assert property (seq_take |=> busy [*8])
    else $error("refresh not taken");
  a_long_record: assert property (seq_take ##0 (ctrl[2] || ctrl[3]) |=>
    len == `PPM_LEN_LONG)
    else $error("long record length wrong");
endmodule
`default_nettype wire

// ==== hdl/ppm_cfg.svh ====
// Constants of the pulse parameter measurement block
`ifndef PPM_CFG_SVH
`define PPM_CFG_SVH
// ------------------------------------------------------------
// Register map (byte addresses)
// ------------------------------------------------------------
`define PPM_A_CTRL 12'h000
`define PPM_A_SLOTS 12'h004
`define PPM_A_STAT 12'h008
`define PPM_A_RES0 12'h010
`define PPM_A_RES1 12'h014
`define PPM_A_RES2 12'h018
`define PPM_A_RES3 12'h01C
`define PPM_CTRL_DENSE 2
`define PPM_CTRL_ACCUM 3
`define PPM_CTRL_RST 4'h0
`define PPM_SLOTS_RST 20'h62420
// ------------------------------------------------------------
// Record lengths and level fractions
// ------------------------------------------------------------
`define PPM_LEN_NORM 14'h0400
`define PPM_LEN_LONG 14'h2000
`define PPM_PEAK_PCT 24'h000005
`define PPM_LO_PCT 24'h00000A
`define PPM_MID_PCT 24'h000032
`define PPM_HI_PCT 24'h00005A
`define PPM_PCT_FULL 24'h000064
`define PPM_RATE_SCALE 32'h00989680
`endif

// ==== hdl/ppm_pkg.sv ====
// Types of the pulse parameter measurement block
package ppm_pkg;
  typedef enum logic [4:0] {
    PAR_REPETITION_RATE, PAR_PER, PAR_RISE, PAR_FALL, PAR_PWID, PAR_NWID, PAR_DUTY,
    PAR_MIN, PAR_MAX, PAR_PP, PAR_BASE, PAR_TOP, PAR_AMP, PAR_PRE,
    PAR_OVER, PAR_RMS, PAR_AVG
  } ppm_par_t;
  typedef enum logic [2:0] {M_OFF, M_VCUR, M_TCUR, M_XCUR, M_PARAM} ppm_meas_t;
  typedef enum logic [2:0] {
    S_IDLE, S_HIST, S_LVL, S_THR, S_EDGE, S_MATH, S_ROOT, S_DONE
  } ppm_state_t;
  typedef struct packed {
    ppm_par_t par;
    logic [1:0] chan;
    logic [31:0] value;
  } ppm_readout_t;
endpackage

// ==== dv/ppm_rec_model.sv ====
// Record memory model feeding the measurement engine
`timescale 1ns/10ps
`default_nettype none
module ppm_rec_model (
  // Clock
  input wire logic clk_sys,
  // Record port
  input wire logic [12:0] rec_addr,
  input wire logic [1:0] kind,
  output logic [7:0] rec_data
);
  // Kinds: flat, square starting low, square starting high; 100-sample halves
  function automatic logic [7:0] sample(input logic [1:0] k, input logic [12:0] a);
    logic hi;
    hi = ((a / 13'h0064) % 13'h0002) == 13'h0001;
    if (k == 2'h0) return 8'h32;
    if (k == 2'h2) hi = !hi;
    if (k == 2'h1 && a == 13'h0000) return 8'h05;
    if (k == 2'h1 && a == 13'h0064) return 8'hE6;
    if (k == 2'h2 && a == 13'h0064) return 8'h05;
    return hi ? 8'hC8 : 8'h14;
  endfunction
  // Data follows the address one cycle later; kind only changes between runs
  always_ff @(posedge clk_sys) begin
    rec_data <= sample(kind, rec_addr);
  end
endmodule
`default_nettype wire

// ==== dv/ppm_top_bench.sv ====
// Self-checking bench for the pulse parameter measurement block
`timescale 1ns/10ps
`default_nettype none
`include "ppm_cfg.svh"
module ppm_top_bench;
  import ppm_pkg::*;
  logic clk_sys = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, rec_refresh = 1'b0, busy, er;
  logic [3:0] keys = 4'h0;
  wire key_measure = keys[0], key_select = keys[1], knob_up = keys[2], knob_down = keys[3];
  logic [7:0] rec_data;
  logic [12:0] rec_addr;
  logic [1:0] rec_chan, kind = 2'h0;
  ppm_readout_t [3:0] readout;
  ppm_meas_t meas_mode;
  logic [2:0] highlight;
  int n_fail = 0, checks = 0, cyc = 0;
  ppm_top i_dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rec_refresh(rec_refresh), .rec_data(rec_data), .rec_addr(rec_addr), .rec_chan(rec_chan),
    .key_measure(key_measure), .key_select(key_select), .knob_up(knob_up),
    .knob_down(knob_down), .readout(readout), .meas_mode(meas_mode), .highlight(highlight),
    .busy(busy));
  ppm_rec_model i_rec (.clk_sys(clk_sys), .rec_addr(rec_addr), .kind(kind), .rec_data(rec_data));
  // 25 MHz clock; the ceiling allows about twice the expected run
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 90000) begin
      n_fail++;
      print_verdict();
    end
  end
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Pins are synchronised inside, so hold each level for several cycles
  task automatic press(input int k);
    @(posedge clk_sys);
    keys[k] <= 1'b1;
    repeat (5) @(posedge clk_sys);
    keys[k] <= 1'b0;
    repeat (5) @(posedge clk_sys);
  endtask
  // Program slots and control, refresh one record, compare the four readouts
  task automatic run(input logic [1:0] k, input logic [3:0] ctl, input int p0, p1, p2, p3,
                     input logic [31:0] e0, e1, e2, e3);
    logic [31:0] e[4];
    int p[4];
    e = '{e0, e1, e2, e3};
    p = '{p0, p1, p2, p3};
    apb(1'b1, `PPM_A_SLOTS, 32'({5'(p3), 5'(p2), 5'(p1), 5'(p0)}));
    apb(1'b1, `PPM_A_CTRL, 32'(ctl));
    kind <= k;
    rec_refresh <= 1'b1;
    @(posedge clk_sys);
    rec_refresh <= 1'b0;
    repeat (2) @(posedge clk_sys);
    while (busy !== 1'b0) @(posedge clk_sys);
    @(posedge clk_sys);
    for (int i = 0; i < 4; i++) begin
      chk("value", readout[i].value, e[i]);
      chk("code", 32'(readout[i].par), 32'(p[i]));
      chk("chan", 32'(readout[i].chan), 32'(ctl[1:0]));
    end
    chk("rec_chan", 32'(rec_chan), 32'(ctl[1:0]));
    apb(1'b0, `PPM_A_RES0, 32'h0);
    chk("res0", rd, e0);
    $display("Record kind %0d done", k);
  endtask
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    apb(1'b0, `PPM_A_CTRL, 32'h0);
    chk("ctrl", rd, 32'h0);
    apb(1'b0, `PPM_A_SLOTS, 32'h0);
    chk("slots", rd, 32'(`PPM_SLOTS_RST));
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped", {rd[30:0], er}, 32'h1);
    $display("Register reset test done");
    // Flat record: nothing but levels may be nonzero
    run(0, 1, 0, 1, 15, 16, 0, 0, 0, 0);
    run(0, 1, 2, 4, 6, 13, 0, 0, 0, 0);
    // Square wave with spikes; only the first period counts
    run(1, 3, 0, 1, 6, 4, 32'hC350, 32'hC8, 32'h32, 32'h64);
    apb(1'b0, `PPM_A_STAT, 32'h0);
    chk("stat", rd, 32'h1F80);
    run(1, 3, 15, 16, 13, 14, 32'h8E, 32'h6E, 32'hF, 32'h1E);
    run(1, 3, 5, 2, 3, 13, 32'h64, 1, 1, 32'hF);
    run(1, 2, 14, 7, 8, 9, 32'h1E, 5, 32'hE6, 32'hE1);
    run(1, 0, 10, 11, 12, 7, 32'h14, 32'hC8, 32'hB4, 5);
    run(2, 9, 13, 14, 3, 10, 0, 32'hF, 1, 32'h14);
    run(1, 5, 0, 1, 4, 9, 32'hC350, 32'hC8, 32'h64, 32'hE1);
    // Panel keys and knob
    for (int i = 1; i <= 4; i++) begin
      press(0);
      chk("mode", 32'(meas_mode), 32'(i));
    end
    press(2);
    apb(1'b0, `PPM_A_SLOTS, 32'h0);
    chk("knob idle", rd, 32'h49020);
    for (int i = 0; i < 5; i++) begin
      press(1);
      chk("highlight", 32'(highlight), 32'((i % 4) + 1));
    end
    press(2);
    apb(1'b0, `PPM_A_SLOTS, 32'h0);
    chk("knob up", rd, 32'h49021);
    press(3);
    press(3);
    apb(1'b0, `PPM_A_SLOTS, 32'h0);
    chk("knob down", rd, 32'h49030);
    $display("Panel test done");
    print_verdict();
  end
endmodule
`default_nettype wire
